// ---- rtl/boot_mode_control.sv ----
// Bootstrap mode control: reset sampling, flash steering, loader, registers
`timescale 1ns/1ns
module boot_mode_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Strap pins
    input wire logic boot_select_pin,
    input wire logic external_access_pin,
    // Serial link after initialisation
    input wire logic link_ready,
    input wire logic link_is_can,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU flash access
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_fetch,
    input wire logic cpu_read,
    input wire logic cpu_write,
    output logic boot_flash_sel,
    output logic user_flash_sel,
    output logic [19:0] flash_offset,
    output logic access_denied,
    // Start-up RAM port and jump
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_data,
    output logic jump_valid,
    output logic [15:0] jump_addr,
    // Mode outputs
    output logic bootstrap_loader_mode,
    output logic watchdog_disable,
    output logic bus_active_bit,
    output logic boot_from_external,
    output logic can_alt_enable,
    output logic restart_pulse
);
    // ==========================================================
    // Register access helpers
    // ==========================================================
    function automatic logic hits(input logic [4:0] a, input logic [4:0] off);
        hits = a == off;
    endfunction

    logic ack;
    logic wr_fire;
    logic rd_take;
    logic sw_reset_req;
    logic sw_bidir;
    logic restart_pending;
    logic restart_hw;
    logic sample;
    logic boot_active;
    logic segment_map;
    logic [3:0] seg_lines;
    logic load_done;
    logic [7:0] byte_count;
    logic loader_reset;
    logic [31:0] next_readdata;

    // ==========================================================
    // Avalon-MM slave: one wait state on every access
    // ==========================================================
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_fire = avs_write & ack;
    assign rd_take = avs_read & ~ack;

    always_ff @(posedge sys_clk) begin
        if (reset)
            ack <= 1'b0;
        else
            ack <= (avs_read | avs_write) & ~ack;
    end

    always_comb begin
        next_readdata = 32'h00000000;
        if (hits(avs_address, boot_mode_pkg::OFF_MODE_STATUS)) begin
            next_readdata[boot_mode_pkg::STAT_BOOT] = boot_active;
            next_readdata[boot_mode_pkg::STAT_BUS] = bus_active_bit;
            next_readdata[boot_mode_pkg::STAT_EXT] = boot_from_external;
            next_readdata[boot_mode_pkg::STAT_DONE] = load_done;
            next_readdata[boot_mode_pkg::STAT_CAN] = link_is_can;
            next_readdata[boot_mode_pkg::STAT_CAN_ALT] = can_alt_enable;
        end else if (hits(avs_address, boot_mode_pkg::OFF_SYSTEM_CONFIG)) begin
            next_readdata[boot_mode_pkg::CFG_SEG_MAP] = segment_map;
            next_readdata[boot_mode_pkg::CFG_SEG_LO +: 4] = seg_lines;
        end else if (hits(avs_address, boot_mode_pkg::OFF_BUS_CONFIG_ZERO)) begin
            next_readdata[boot_mode_pkg::BUS_ACTIVE_POS] = bus_active_bit;
        end else if (hits(avs_address, boot_mode_pkg::OFF_LOAD_COUNT)) begin
            next_readdata[7:0] = byte_count;
        end
    end

    // Data is latched in the wait cycle so it stands at the completing edge
    always_ff @(posedge sys_clk) begin
        if (reset)
            avs_readdata <= 32'h00000000;
        else if (rd_take)
            avs_readdata <= next_readdata;
    end

    // ==========================================================
    // Reset kinds and strap sampling
    // ==========================================================
    assign sw_reset_req = wr_fire && hits(avs_address, boot_mode_pkg::OFF_RESET_CONTROL)
        && avs_byteenable[0] && avs_writedata[boot_mode_pkg::RST_SOFT];
    assign sw_bidir = avs_writedata[boot_mode_pkg::RST_BIDIR];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            restart_pending <= 1'b1;
            restart_hw <= 1'b1;
        end else if (sw_reset_req) begin
            restart_pending <= 1'b1;
            restart_hw <= sw_bidir & ~external_access_pin;
        end else begin
            restart_pending <= 1'b0;
        end
    end

    // Sampling happens on the first cycle after any reset is released
    assign sample = restart_pending;
    assign restart_pulse = sample;

    always_ff @(posedge sys_clk) begin
        if (reset)
            boot_active <= 1'b0;
        else if (sample)
            boot_active <= restart_hw & ~boot_select_pin;
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            bus_active_bit <= 1'b0;
        else if (sample)
            bus_active_bit <= ~external_access_pin;
        else if (wr_fire && hits(avs_address, boot_mode_pkg::OFF_BUS_CONFIG_ZERO)
                 && avs_byteenable[1])
            bus_active_bit <= avs_writedata[boot_mode_pkg::BUS_ACTIVE_POS];
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            boot_from_external <= 1'b0;
        else if (sample)
            boot_from_external <= ~external_access_pin;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            segment_map <= 1'b0;
            seg_lines <= boot_mode_pkg::SEG_LINES_RESET;
        end else if (sample) begin
            segment_map <= 1'b0;
            seg_lines <= boot_mode_pkg::SEG_LINES_RESET;
        end else if (wr_fire && hits(avs_address, boot_mode_pkg::OFF_SYSTEM_CONFIG)
                     && avs_byteenable[0]) begin
            segment_map <= avs_writedata[boot_mode_pkg::CFG_SEG_MAP];
            seg_lines <= avs_writedata[boot_mode_pkg::CFG_SEG_LO +: 4];
        end
    end

    // ==========================================================
    // Mode outputs
    // ==========================================================
    assign bootstrap_loader_mode = boot_active;
    assign watchdog_disable = boot_active;
    assign can_alt_enable = seg_lines != boot_mode_pkg::SEG_LINES_NO_CAN;

    // ==========================================================
    // Flash steering and start-up loader
    // ==========================================================
    // restriction follows the flag
    flash_access_router u_router (
        .sys_clk(sys_clk),
        .reset(reset),
        .boot_active(boot_active),
        .segment_map(segment_map),
        .cpu_addr(cpu_addr),
        .cpu_fetch(cpu_fetch),
        .cpu_read(cpu_read),
        .cpu_write(cpu_write),
        .boot_flash_sel(boot_flash_sel),
        .user_flash_sel(user_flash_sel),
        .flash_offset(flash_offset),
        .access_denied(access_denied)
    );

    // A new reset restarts the loader; the loaded block is not reloaded otherwise
    assign loader_reset = reset | sample;

    startup_loader u_loader (
        .sys_clk(sys_clk),
        .reset(loader_reset),
        .start(link_ready & boot_active),
        .link_is_can(link_is_can),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_data(ram_data),
        .jump_valid(jump_valid),
        .jump_addr(jump_addr),
        .load_done(load_done),
        .byte_count(byte_count)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_boot_entry: assert property (sample && restart_hw && !boot_select_pin
        |=> boot_active)
        else $error("boot pin low did not enter bootstrap");
    chk_hw_exit: assert property (sample && restart_hw && boot_select_pin
        |=> !boot_active && !watchdog_disable)
        else $error("hardware reset with pin high kept bootstrap");
    chk_sw_exit: assert property (sample && !restart_hw |=> !boot_active)
        else $error("software reset kept bootstrap");
    chk_bus_from_ea: assert property (sample |=> bus_active_bit == !$past(external_access_pin))
        else $error("bus active bit not from external-access pin");
    chk_vector_sel: assert property (sample && !(restart_hw && !boot_select_pin)
        |=> boot_from_external == !$past(external_access_pin))
        else $error("restart vector source wrong");
    chk_map_default: assert property (sample |=> !segment_map)
        else $error("segment map not cleared at reset");
    chk_can_off: assert property (seg_lines == 4'h8 |-> !can_alt_enable)
        else $error("CAN pins active with eight segments");
    chk_degenerate: assert property (sw_reset_req && sw_bidir && !external_access_pin
        ##1 !boot_select_pin |=> boot_active)
        else $error("degenerated reset ignored boot pin");
    chk_flag_holds: assert property (boot_active && !sample |=> boot_active && watchdog_disable)
        else $error("bootstrap flag dropped without reset");
    chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus access not answered within one wait");

    cov_boot_enter: cover property (sample ##1 boot_active);
    cov_sw_exit: cover property (boot_active ##1 sw_reset_req ##2 !boot_active);
endmodule

// ---- rtl/boot_mode_pkg.sv ----
// Constants and types shared by the bootstrap mode controller
// Function
// - Boot pin low at reset enters bootstrap
// - Eight segments keep CAN pins inactive
// - External-access pin sets bus active bit
// - Boot code fetches served from boot flash
// - Boot flash never readable or writable
// - Flash writes decoded only from segment one (code: bootstrap only; normal-mode writes follow the map bit)
// - Flash reads follow the segment map bit
// - Segment map bit defaults to zero
// - Load 32 UART or 128 CAN bytes
// - Store bytes upward from FA40 in RAM
// - Jump to FA40, mode stays active
// - Watchdog off, flash restricted while bootstrapping
// - Software reset exits, hardware needs pin high
// - Restart at zero, user or external
// - Degenerated software reset resamples boot pin
package boot_mode_pkg;
    // Register byte offsets
    localparam logic [4:0] OFF_MODE_STATUS = 5'h00;
    localparam logic [4:0] OFF_SYSTEM_CONFIG = 5'h04;
    localparam logic [4:0] OFF_BUS_CONFIG_ZERO = 5'h08;
    localparam logic [4:0] OFF_RESET_CONTROL = 5'h0C;
    localparam logic [4:0] OFF_LOAD_COUNT = 5'h10;
    // Field positions
    localparam int STAT_BOOT = 0;
    localparam int STAT_BUS = 1;
    localparam int STAT_EXT = 2;
    localparam int STAT_DONE = 3;
    localparam int STAT_CAN = 4;
    localparam int STAT_CAN_ALT = 5;
    localparam int CFG_SEG_MAP = 0;
    localparam int CFG_SEG_LO = 1;
    localparam int BUS_ACTIVE_POS = 10;
    localparam int RST_SOFT = 0;
    localparam int RST_BIDIR = 1;
    // Reset value and CAN-off segment code
    localparam logic [3:0] SEG_LINES_RESET = 4'h0;
    localparam logic [3:0] SEG_LINES_NO_CAN = 4'h8;
    // Memory map
    localparam logic [23:0] BOOT_FLASH_TOP = 24'h001FFF;
    localparam logic [23:0] SEG0_USER_TOP = 24'h007FFF;
    localparam logic [23:0] SEG1_BASE = 24'h010000;
    localparam logic [23:0] FLASH_AREA_TOP = 24'h08FFFF;
    localparam logic [15:0] RAM_LOAD_BASE = 16'hFA40;
    // Start-up block lengths
    localparam logic [7:0] UART_LOAD_LEN = 8'h20;
    localparam logic [7:0] CAN_LOAD_LEN = 8'h80;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_LOAD = 2'b01,
        LD_JUMP = 2'b10,
        LD_DONE = 2'b11
    } loader_state_e;
endpackage

// ---- rtl/flash_access_router.sv ----
// Internal flash access steering for boot and normal modes
`timescale 1ns/1ns
module flash_access_router (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Mode
    input wire logic boot_active,
    input wire logic segment_map,
    // CPU access
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_fetch,
    input wire logic cpu_read,
    input wire logic cpu_write,
    // Routed access
    output logic boot_flash_sel,
    output logic user_flash_sel,
    output logic [19:0] flash_offset,
    output logic access_denied
);
    // Hit flag above a user flash offset
    function automatic logic [20:0] user_map(input logic [23:0] a, input logic map);
        logic [23:0] rel;
        rel = a - boot_mode_pkg::SEG1_BASE;
        if (a >= boot_mode_pkg::SEG1_BASE)
            user_map = {1'b1, rel[19:0]};
        else if (!map && a <= boot_mode_pkg::SEG0_USER_TOP)
            user_map = {1'b1, a[19:0]};
        else
            user_map = 21'h000000;
    endfunction

    logic in_area;
    logic any_req;
    logic next_boot;
    logic next_user;
    logic next_deny;
    logic [19:0] next_off;
    logic [20:0] hit;

    assign in_area = cpu_addr <= boot_mode_pkg::FLASH_AREA_TOP;
    assign any_req = cpu_fetch | cpu_read | cpu_write;
    assign hit = user_map(cpu_addr, segment_map);

    always_comb begin
        next_boot = 1'b0;
        next_user = 1'b0;
        next_deny = 1'b0;
        next_off = 20'h00000;
        if (in_area && any_req) begin
            if (!boot_active) begin
                next_user = hit[20];
                next_deny = ~hit[20];
                next_off = hit[19:0];
            end else if (cpu_fetch) begin
                next_boot = 1'b1;
                next_off = {7'h00, cpu_addr[12:0]};
            end else if (cpu_write) begin
                next_user = cpu_addr >= boot_mode_pkg::SEG1_BASE;
                next_deny = cpu_addr < boot_mode_pkg::SEG1_BASE;
                next_off = hit[19:0];
            end else begin
                next_user = hit[20];
                next_deny = ~hit[20];
                next_off = hit[19:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_flash_sel <= 1'b0;
            user_flash_sel <= 1'b0;
            flash_offset <= 20'h00000;
            access_denied <= 1'b0;
        end else begin
            boot_flash_sel <= next_boot;
            user_flash_sel <= next_user;
            flash_offset <= next_off;
            access_denied <= next_deny;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_fetch_redirect: assert property (boot_active && cpu_fetch && in_area |=> boot_flash_sel)
        else $error("boot fetch not redirected");
    chk_boot_hidden: assert property (boot_active && !cpu_fetch |=> !boot_flash_sel)
        else $error("boot flash reached by data access");
    chk_write_seg1: assert property (boot_active && cpu_write && !cpu_fetch
        && cpu_addr < boot_mode_pkg::SEG1_BASE |=> access_denied && !user_flash_sel)
        else $error("segment zero write accepted");
    chk_read_map: assert property (boot_active && cpu_read && !cpu_fetch && !cpu_write
        && segment_map && cpu_addr < boot_mode_pkg::SEG1_BASE |=> access_denied)
        else $error("segment zero read with map set");
    cov_boot_fetch: cover property (boot_active && cpu_fetch ##1 boot_flash_sel);
endmodule

// ---- rtl/startup_loader.sv ----
// Start-up block loader into dual-port RAM
`timescale 1ns/1ns
module startup_loader (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    input wire logic start,
    input wire logic link_is_can,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    // RAM and jump
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_data,
    output logic jump_valid,
    output logic [15:0] jump_addr,
    output logic load_done,
    output logic [7:0] byte_count
);
    boot_mode_pkg::loader_state_e state;
    logic [7:0] load_len;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= boot_mode_pkg::LD_IDLE;
            load_len <= boot_mode_pkg::UART_LOAD_LEN;
            byte_count <= 8'h00;
            ram_we <= 1'b0;
            ram_addr <= 16'h0000;
            ram_data <= 8'h00;
            jump_valid <= 1'b0;
            jump_addr <= 16'h0000;
        end else begin
            ram_we <= 1'b0;
            jump_valid <= 1'b0;
            case (state)
                boot_mode_pkg::LD_IDLE: begin
                    if (start) begin
                        load_len <= link_is_can ? boot_mode_pkg::CAN_LOAD_LEN
                                                : boot_mode_pkg::UART_LOAD_LEN;
                        byte_count <= 8'h00;
                        state <= boot_mode_pkg::LD_LOAD;
                    end
                end
                boot_mode_pkg::LD_LOAD: begin
                    if (rx_valid) begin
                        ram_we <= 1'b1;
                        ram_addr <= boot_mode_pkg::RAM_LOAD_BASE + {8'h00, byte_count};
                        ram_data <= rx_byte;
                        byte_count <= byte_count + 8'h01;
                        if (byte_count == load_len - 8'h01)
                            state <= boot_mode_pkg::LD_JUMP;
                    end
                end
                boot_mode_pkg::LD_JUMP: begin
                    jump_valid <= 1'b1;
                    jump_addr <= boot_mode_pkg::RAM_LOAD_BASE;
                    state <= boot_mode_pkg::LD_DONE;
                end
                boot_mode_pkg::LD_DONE: state <= boot_mode_pkg::LD_DONE;
                default: state <= boot_mode_pkg::LD_IDLE;
            endcase
        end
    end

    assign load_done = state == boot_mode_pkg::LD_DONE;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_load_length: assert property (jump_valid |-> byte_count == load_len
        && (load_len == 8'h20 || load_len == 8'h80))
        else $error("wrong start-up block length");
    chk_ram_order: assert property (ram_we
        |-> ram_addr == boot_mode_pkg::RAM_LOAD_BASE + {8'h00, byte_count} - 16'h0001)
        else $error("start-up byte stored out of order");
    chk_jump_target: assert property (jump_valid
        |-> jump_addr == boot_mode_pkg::RAM_LOAD_BASE ##1 load_done)
        else $error("bad jump after loading");
    cov_uart_load: cover property (jump_valid && load_len == 8'h20);
    cov_can_load: cover property (jump_valid && load_len == 8'h80);
endmodule

// ---- tb/boot_host_model.sv ----
// Serial host that streams the start-up block after the link is ready
`timescale 1ns/1ns
module boot_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bench control
    input wire logic send_req,
    input wire logic [7:0] send_len,
    input wire logic [1:0] gap,
    output logic busy,
    // Link towards the loader
    output logic link_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic [7:0] sent;
    logic [1:0] wait_cnt;
    // ==========================================
    // Byte stream
    always_ff @(posedge sys_clk) begin
        // receive line only driven, idle high
        rx_byte <= 8'hFF;
        link_ready <= 1'b0;
        rx_valid <= 1'b0;
        if (reset) begin
            busy <= 1'b0;
            sent <= 8'h00;
            wait_cnt <= 2'h0;
        end else if (!busy) begin
            if (send_req) begin
                busy <= 1'b1;
                link_ready <= 1'b1;
                sent <= 8'h00;
                wait_cnt <= 2'h2;
            end
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else if (sent == send_len) begin
            busy <= 1'b0;
        end else begin
            // host sends the block, plus any extra bytes asked for
            rx_valid <= 1'b1;
            rx_byte <= sent ^ 8'hA5;
            sent <= sent + 8'h01;
            wait_cnt <= gap;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the bootstrap mode controller
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [23:0] addr; logic [1:0] kind; logic [2:0] exp;} row_s;
    logic sys_clk, reset, boot_select_pin, external_access_pin, link_ready, link_is_can;
    logic rx_valid, avs_read, avs_write, avs_waitrequest, cpu_fetch, cpu_read, cpu_write;
    logic boot_flash_sel, user_flash_sel, access_denied, ram_we, jump_valid;
    logic bootstrap_loader_mode, watchdog_disable, bus_active_bit, boot_from_external;
    logic can_alt_enable, send_req, busy, gap_sel, restart_pulse;
    logic [7:0] rx_byte, ram_data, send_len, wr_idx;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [23:0] cpu_addr;
    logic [19:0] flash_offset;
    logic [15:0] ram_addr, jump_addr;
    int fails, num_checks, jumps, cyc;
    // Fetch, read, write; expected {boot sel, user sel, denied}
    row_s rows [0:5] = '{'{24'h000100, 2'h0, 3'h4}, '{24'h012345, 2'h0, 3'h4},
        '{24'h000010, 2'h1, 3'h2}, '{24'h000010, 2'h2, 3'h1},
        '{24'h010000, 2'h2, 3'h2}, '{24'h008000, 2'h1, 3'h1}};

    boot_mode_control boot_mode_control_i (.sys_clk(sys_clk), .reset(reset),
        .boot_select_pin(boot_select_pin), .external_access_pin(external_access_pin),
        .link_ready(link_ready), .link_is_can(link_is_can), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
        .cpu_read(cpu_read), .cpu_write(cpu_write), .boot_flash_sel(boot_flash_sel),
        .user_flash_sel(user_flash_sel), .flash_offset(flash_offset),
        .access_denied(access_denied), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_data(ram_data), .jump_valid(jump_valid), .jump_addr(jump_addr),
        .bootstrap_loader_mode(bootstrap_loader_mode), .watchdog_disable(watchdog_disable),
        .bus_active_bit(bus_active_bit), .boot_from_external(boot_from_external),
        .can_alt_enable(can_alt_enable), .restart_pulse(restart_pulse));
    boot_host_model boot_host_model_i (.sys_clk(sys_clk), .reset(reset),
        .send_req(send_req), .send_len(send_len), .gap({1'b0, gap_sel}), .busy(busy),
        .link_ready(link_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));

    // ==========================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    // RAM writes and jump seen mid-cycle, where registered outputs are settled
    always @(negedge sys_clk) begin
        if (ram_we === 1'b1) begin
            check({ram_addr, ram_data}, {16'hFA40 + {8'h00, wr_idx}, wr_idx ^ 8'hA5});
            wr_idx = wr_idx + 8'h01;
        end
        if (jump_valid === 1'b1) begin
            jumps++;
            check(jump_addr, 16'hFA40);
        end
    end

    // ==========================================
    // Bus, flash and host drivers
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= data;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic flash(input logic [23:0] addr, input logic [1:0] kind);
        @(posedge sys_clk);
        cpu_addr <= addr;
        {cpu_write, cpu_read, cpu_fetch} <= 3'b001 << kind;
        @(posedge sys_clk);
        {cpu_write, cpu_read, cpu_fetch} <= 3'b000;
        #1;
    endtask
    task automatic load(input logic can, input logic [7:0] len, input logic slow);
        int n;
        n = 0;
        wr_idx = 8'h00;
        jumps = 0;
        @(posedge sys_clk);
        link_is_can <= can;
        send_len <= len;
        gap_sel <= slow;
        send_req <= 1'b1;
        @(posedge sys_clk);
        send_req <= 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (busy === 1'b1 && n < 2000);
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {fails, num_checks, jumps, cyc} = '0;
        {reset, boot_select_pin, external_access_pin} = 3'b101;
        {link_is_can, avs_read, avs_write, cpu_fetch, cpu_read, cpu_write} = '0;
        {send_req, gap_sel, avs_address, avs_writedata, cpu_addr} = '0;
        {avs_byteenable, send_len, wr_idx} = {4'hF, 8'h00, 8'h00};
        do_reset();
        check({bootstrap_loader_mode, watchdog_disable, bus_active_bit}, 3'b110);
        bus(1'b0, boot_mode_pkg::OFF_MODE_STATUS, 32'h0);
        check(rd, 32'h21);
        bus(1'b0, boot_mode_pkg::OFF_SYSTEM_CONFIG, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 5'h14, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            flash(rows[i].addr, rows[i].kind);
            check({boot_flash_sel, user_flash_sel, access_denied}, rows[i].exp);
            if (rows[i].kind == 2'h0) check(flash_offset, {7'h00, rows[i].addr[12:0]});
        end
        bus(1'b1, boot_mode_pkg::OFF_SYSTEM_CONFIG, 32'h1);
        flash(24'h000010, 2'h1);
        check({boot_flash_sel, user_flash_sel, access_denied}, 3'h1);
        flash(24'h010010, 2'h1);
        check({boot_flash_sel, user_flash_sel, access_denied}, 3'h2);
        bus(1'b1, boot_mode_pkg::OFF_SYSTEM_CONFIG, 32'h10);
        check(can_alt_enable, 1'b0);
        bus(1'b1, boot_mode_pkg::OFF_SYSTEM_CONFIG, 32'h08);
        check(can_alt_enable, 1'b1);
        // One byte past the block must be ignored
        load(1'b0, 8'd33, 1'b0);
        check({wr_idx, jumps[7:0], bootstrap_loader_mode}, {8'd32, 8'd1, 1'b1});
        bus(1'b1, boot_mode_pkg::OFF_RESET_CONTROL, 32'h1);
        check(restart_pulse, 1'b1);
        repeat (3) @(negedge sys_clk);
        check({bootstrap_loader_mode, watchdog_disable}, 2'b00);
        flash(24'h000100, 2'h0);
        check({boot_flash_sel, user_flash_sel, boot_from_external}, 3'b010);
        @(posedge sys_clk);
        external_access_pin <= 1'b0;
        do_reset();
        check({bootstrap_loader_mode, bus_active_bit, boot_from_external}, 3'b111);
        load(1'b1, 8'd128, 1'b1);
        check({wr_idx, jumps[7:0], bootstrap_loader_mode}, {8'd128, 8'd1, 1'b1});
        // Bidirectional soft reset with external boot resamples the pin
        bus(1'b1, boot_mode_pkg::OFF_RESET_CONTROL, 32'h3);
        repeat (3) @(negedge sys_clk);
        check(bootstrap_loader_mode, 1'b1);
        @(posedge sys_clk);
        boot_select_pin <= 1'b1;
        do_reset();
        check({bootstrap_loader_mode, boot_from_external}, 2'b01);
        finish_test();
    end
endmodule
